//--- led_mode_regs.sv
// Mode, output-state and duty registers of a 16-channel LED driver, with the
// output stage that turns channel states and duty values into drive levels.
// Assumes a bus slave on sys_clk that gives write/read strobes and STOP/ACK events.
`timescale 1ns/1ps
module led_mode_regs
  import led_mode_pkg::*;
#(
  parameter int CHANNELS       = 16,
  parameter int OSC_START_CYC  = OSC_START_CYCLES
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Register access from the bus slave
  input  wire logic [6:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Bus events and slave status
  input  wire logic                bus_stop,
  input  wire logic                bus_ack,
  input  wire logic                autoinc_active_flag,
  // Fault detection
  input  wire logic [CHANNELS-1:0] fault_detect,
  input  wire logic                thermal_fault_flag,
  // External output enable pin, active low
  input  wire logic                oe_n_pin,
  // Mode controls to the bus slave and gradation engine
  output logic                     autoinc_range_hi,
  output logic                     autoinc_range_lo,
  output logic                     subaddr_one_enable,
  output logic                     subaddr_two_enable,
  output logic                     subaddr_three_enable,
  output logic                     broadcast_addr_enable,
  output logic                     group_dim_or_blink,
  output logic                     output_update_timing,
  output logic                     exponential_ramp_select,
  // Oscillator and outputs
  output logic                     osc_enable,
  output logic [CHANNELS-1:0]      led_drive,
  output logic [CHANNELS-1:0]      output_fault_flags,
  output logic                     error_summary
);

  localparam int OSC_CW  = $clog2(OSC_START_CYC + 1);
  localparam int ACC_W   = $clog2(PWM_PERIOD_CYCLES + PWM_STEPS + 1);
  localparam int BLINK_W = 8 + BLINK_STEP_SHIFT;
  localparam logic [ACC_W-1:0] ACC_STEP   = ACC_W'(PWM_STEPS);
  localparam logic [ACC_W-1:0] ACC_PERIOD = ACC_W'(PWM_PERIOD_CYCLES);

  // Drive level of one channel from its state and the PWM phases
  function automatic logic chan_drive(input logic [1:0] st, input logic [7:0] duty,
                                      input logic [7:0] ph, input logic grp_on,
                                      input logic run);
    logic ind;
    ind = run && ((duty == DUTY_FULL) || (ph < duty));
    case (st)
      CH_OFF:     chan_drive = 1'b0;
      CH_FULL:    chan_drive = 1'b1;
      CH_PWM:     chan_drive = ind;
      CH_PWM_GRP: chan_drive = ind && grp_on;
      default:    chan_drive = 1'b0;
    endcase
  endfunction

  logic [6:0]            ctrl1;
  logic                  dim_blink;
  logic                  upd;
  logic                  exp_sel;
  logic [31:0]           state_staged;
  logic [31:0]           state_act;
  logic [7:0]            grp_duty_staged;
  logic [7:0]            grp_period_staged;
  logic [7:0]            grp_duty_act;
  logic [7:0]            grp_period_act;
  logic                  apply_q;
  logic [CHANNELS-1:0]   fault_flags;
  logic [OSC_CW-1:0]     osc_cnt;
  logic                  osc_ready;
  logic [ACC_W-1:0]      step_acc;
  logic [7:0]            phase;
  logic [7:0]            gphase;
  logic [BLINK_W-1:0]    blink_cnt;
  logic                  scan_run;
  logic [3:0]            scan_idx;
  logic                  scan_vld;
  logic [3:0]            scan_ch;
  logic [CHANNELS-1:0]   led_raw;
  logic                  oe_s1;
  logic                  oe_s2;
  logic                  oe_s3;
  logic                  oe_off;
  logic                  rd1;
  logic                  duty_sel1;
  logic [7:0]            local1;
  logic [7:0]            duty_rd_data;
  logic [7:0]            duty_scan_data;

  // Address decode
  wire        wr_ctrl1     = reg_wr && (reg_addr == ADDR_CTRL1);
  wire        wr_ctrl2     = reg_wr && (reg_addr == ADDR_CTRL2);
  wire        hit_state    = (reg_addr >= ADDR_OUT_STATE0) && (reg_addr <= ADDR_OUT_STATE3);
  wire        wr_state     = reg_wr && hit_state;
  wire [6:0]  state_off    = reg_addr - ADDR_OUT_STATE0;
  wire [1:0]  state_idx    = state_off[1:0];
  wire        wr_gduty     = reg_wr && (reg_addr == ADDR_GROUP_DUTY);
  wire        wr_gperiod   = reg_wr && (reg_addr == ADDR_GROUP_PERIOD);
  wire        hit_duty     = (reg_addr >= ADDR_DUTY_FIRST) && (reg_addr <= ADDR_DUTY_LAST);
  wire        wr_duty      = reg_wr && hit_duty;
  wire        wr_duty_all  = reg_wr && (reg_addr == ADDR_DUTY_ALL);
  wire [3:0]  duty_idx     = {reg_addr[4], reg_addr[2:0]};
  wire        clr_faults   = wr_ctrl2 && reg_wdata[BIT_ERRCLR];
  wire        sleeping     = ctrl1[BIT_SLEEP];

  // Settings move to the output stage on the chosen bus event
  wire        apply_evt    = upd ? bus_ack : bus_stop;

  // Sticky fault flags; a fault seen in the clear cycle still sets its flag
  wire [CHANNELS-1:0] next_fault_flags = (clr_faults ? '0 : fault_flags) | fault_detect;

  // PWM time base
  wire [ACC_W-1:0] acc_sum   = step_acc + ACC_STEP;
  wire             step_tick = acc_sum >= ACC_PERIOD;
  wire             pwm_wrap  = step_tick && (phase == 8'hff);
  wire [BLINK_W-1:0] blink_last = {grp_period_act, {BLINK_STEP_SHIFT{1'b1}}};
  wire             grp_on    = gphase < grp_duty_act;

  // Read-back value of the non-memory registers
  logic [7:0] local_rdata;
  always_comb begin
    local_rdata = 8'h00;
    case (reg_addr)
      ADDR_CTRL1: begin
        local_rdata = {autoinc_active_flag, ctrl1};
      end
      ADDR_CTRL2: begin
        local_rdata                = 8'h00;
        local_rdata[BIT_THERMAL]   = thermal_fault_flag;
        local_rdata[BIT_ERROR]     = |fault_flags;
        local_rdata[BIT_DIMBLINK]  = dim_blink;
        local_rdata[BIT_ERRCLR]    = 1'b0;
        local_rdata[BIT_UPD]       = upd;
        local_rdata[BIT_EXP]       = exp_sel;
        local_rdata[BIT_RSVD1]     = 1'b0;
        local_rdata[BIT_RSVD0]     = 1'b1;
      end
      ADDR_GROUP_DUTY:   local_rdata = grp_duty_staged;
      ADDR_GROUP_PERIOD: local_rdata = grp_period_staged;
      ADDR_FAULT_LO:     local_rdata = fault_flags[7:0];
      ADDR_FAULT_HI:     local_rdata = fault_flags[15:8];
      default: begin
        if (hit_state) begin
          local_rdata = state_staged[state_idx*8 +: 8];
        end
      end
    endcase
  end

  // Mode registers; read-only bits have no storage, so writes to them vanish
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1     <= CTRL1_RESET;
      dim_blink <= 1'b0;
      upd       <= 1'b0;
      exp_sel   <= 1'b0;
    end else begin
      if (wr_ctrl1) begin
        ctrl1 <= reg_wdata[6:0];
      end
      if (wr_ctrl2) begin
        dim_blink <= reg_wdata[BIT_DIMBLINK];
        upd       <= reg_wdata[BIT_UPD];
        exp_sel   <= reg_wdata[BIT_EXP];
      end
    end
  end

  // Staged output state and group settings, as the host sees them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_staged      <= {4{OUT_STATE_RESET}};
      grp_duty_staged   <= GROUP_DUTY_RESET;
      grp_period_staged <= GROUP_PER_RESET;
    end else begin
      if (wr_state) begin
        state_staged[state_idx*8 +: 8] <= reg_wdata;
      end
      if (wr_gduty) begin
        grp_duty_staged <= reg_wdata;
      end
      if (wr_gperiod) begin
        grp_period_staged <= reg_wdata;
      end
    end
  end

  // Active copies, loaded one edge after STOP or ACK so a same-cycle write is caught
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      apply_q        <= 1'b0;
      state_act      <= {4{OUT_STATE_RESET}};
      grp_duty_act   <= GROUP_DUTY_RESET;
      grp_period_act <= GROUP_PER_RESET;
    end else begin
      apply_q <= apply_evt;
      if (apply_q) begin
        state_act      <= state_staged;
        grp_duty_act   <= grp_duty_staged;
        grp_period_act <= grp_period_staged;
      end
    end
  end

  // Fault flags and summary; detection again after a clear re-sets them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_flags        <= '0;
      output_fault_flags <= '0;
      error_summary      <= 1'b0;
    end else begin
      fault_flags        <= next_fault_flags;
      output_fault_flags <= next_fault_flags;
      error_summary      <= |next_fault_flags;
    end
  end

  // Oscillator start; PWM is held off until the start window has passed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable <= 1'b0;
      osc_cnt    <= '0;
      osc_ready  <= 1'b0;
    end else begin
      osc_enable <= !sleeping;
      if (sleeping) begin
        osc_cnt   <= '0;
        osc_ready <= 1'b0;
      end else if (!osc_ready) begin
        if (osc_cnt == OSC_CW'(OSC_START_CYC - 1)) begin
          osc_ready <= 1'b1;
        end else begin
          osc_cnt <= osc_cnt + 1'b1;
        end
      end
    end
  end

  // Fractional step generator: 256 steps per 8000 cycles gives exactly 31.25 kHz
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      step_acc <= '0;
    end else begin
      step_acc <= step_tick ? acc_sum - ACC_PERIOD : acc_sum;
    end
  end

  // Individual and group phase; frozen at zero while the oscillator is stopped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase     <= '0;
      gphase    <= '0;
      blink_cnt <= '0;
    end else if (!osc_ready) begin
      phase     <= '0;
      gphase    <= '0;
      blink_cnt <= '0;
    end else begin
      if (step_tick) begin
        phase <= phase + 1'b1;
      end
      if (pwm_wrap) begin
        if (!dim_blink) begin
          gphase <= gphase + 1'b1;
        end else if (blink_cnt == blink_last) begin
          blink_cnt <= '0;
          gphase    <= gphase + 1'b1;
        end else begin
          blink_cnt <= blink_cnt + 1'b1;
        end
      end
    end
  end

  // Channel scan after each step; the 31-cycle step leaves room for 16 reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scan_run <= 1'b0;
      scan_idx <= '0;
      scan_vld <= 1'b0;
      scan_ch  <= '0;
    end else begin
      scan_vld <= scan_run;
      scan_ch  <= scan_idx;
      if (step_tick) begin
        scan_run <= 1'b1;
        scan_idx <= '0;
      end else if (scan_run) begin
        scan_idx <= scan_idx + 1'b1;
        if (scan_idx == 4'hf) begin
          scan_run <= 1'b0;
        end
      end
    end
  end

  // Per-channel drive levels from the scanned duty value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      led_raw <= '0;
    end else if (scan_vld) begin
      led_raw[scan_ch] <= chan_drive(state_act[scan_ch*2 +: 2], duty_scan_data, phase,
                                     grp_on, osc_ready);
    end
  end

  // Enable pin synchroniser; a change counts when the last two stages agree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oe_s1  <= 1'b1;
      oe_s2  <= 1'b1;
      oe_s3  <= 1'b1;
      oe_off <= 1'b1;
    end else begin
      oe_s1 <= oe_n_pin;
      oe_s2 <= oe_s1;
      oe_s3 <= oe_s2;
      if (oe_s2 == oe_s3) begin
        oe_off <= oe_s3;
      end
    end
  end

  // Output drive; the pin gates every channel, including fully-on ones
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      led_drive <= '0;
    end else begin
      led_drive <= oe_off ? '0 : led_raw;
    end
  end

  // Read pipeline: memory and local data both settle one edge after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd1        <= 1'b0;
      duty_sel1  <= 1'b0;
      local1     <= '0;
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      rd1        <= reg_rd;
      duty_sel1  <= hit_duty;
      local1     <= local_rdata;
      reg_rvalid <= rd1;
      if (rd1) begin
        reg_rdata <= duty_sel1 ? duty_rd_data : local1;
      end
    end
  end

  // Mode control outputs, straight from the mode flip-flops
  assign autoinc_range_hi        = ctrl1[BIT_AI_HI];
  assign autoinc_range_lo        = ctrl1[BIT_AI_LO];
  assign subaddr_one_enable      = ctrl1[BIT_SA1];
  assign subaddr_two_enable      = ctrl1[BIT_SA2];
  assign subaddr_three_enable    = ctrl1[BIT_SA3];
  assign broadcast_addr_enable   = ctrl1[BIT_BCAST];
  assign group_dim_or_blink      = dim_blink;
  assign output_update_timing    = upd;
  assign exponential_ramp_select = exp_sel;

  // Duty store; the broadcast duty write fills all sixteen words
  duty_mem #(
    .WIDTH (8),
    .DEPTH (CHANNELS),
    .AW    (4)
  ) u_duty (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_en     (wr_duty),
    .wr_all    (wr_duty_all),
    .wr_addr   (duty_idx),
    .wr_data   (reg_wdata),
    .rd_a_addr (duty_idx),
    .rd_a_data (duty_rd_data),
    .rd_b_addr (scan_idx),
    .rd_b_data (duty_scan_data)
  );

endmodule

//--- led_mode_pkg.sv
// Constants shared by the mode and output-state register bank.
// Assumes a 250 MHz system clock and a 7-bit register address from the bus slave.
package led_mode_pkg;

  // Clock and timing
  localparam int CLK_MHZ           = 250;
  localparam int CLK_HZ            = CLK_MHZ * 1_000_000;
  localparam int OSC_START_US      = 500;
  localparam int OSC_START_CYCLES  = OSC_START_US * CLK_MHZ;
  localparam int PWM_HZ            = 31_250;
  localparam int PWM_STEPS         = 256;
  localparam int PWM_PERIOD_CYCLES = CLK_HZ / PWM_HZ;
  localparam int BLINK_STEP_SHIFT  = 3;

  // Register addresses
  localparam logic [6:0] ADDR_CTRL1        = 7'h00;
  localparam logic [6:0] ADDR_CTRL2        = 7'h01;
  localparam logic [6:0] ADDR_OUT_STATE0   = 7'h02;
  localparam logic [6:0] ADDR_OUT_STATE3   = 7'h05;
  localparam logic [6:0] ADDR_GROUP_DUTY   = 7'h06;
  localparam logic [6:0] ADDR_GROUP_PERIOD = 7'h07;
  localparam logic [6:0] ADDR_DUTY_FIRST   = 7'h08;
  localparam logic [6:0] ADDR_DUTY_LAST    = 7'h17;
  localparam logic [6:0] ADDR_DUTY_ALL     = 7'h44;
  localparam logic [6:0] ADDR_FAULT_LO     = 7'h46;
  localparam logic [6:0] ADDR_FAULT_HI     = 7'h47;

  // First mode register fields
  localparam int BIT_AUTOINC_FLAG = 7;
  localparam int BIT_AI_HI        = 6;
  localparam int BIT_AI_LO        = 5;
  localparam int BIT_SLEEP        = 4;
  localparam int BIT_SA1          = 3;
  localparam int BIT_SA2          = 2;
  localparam int BIT_SA3          = 1;
  localparam int BIT_BCAST        = 0;

  // Second mode register fields
  localparam int BIT_THERMAL  = 7;
  localparam int BIT_ERROR    = 6;
  localparam int BIT_DIMBLINK = 5;
  localparam int BIT_ERRCLR   = 4;
  localparam int BIT_UPD      = 3;
  localparam int BIT_EXP      = 2;
  localparam int BIT_RSVD1    = 1;
  localparam int BIT_RSVD0    = 0;

  // Reset values and the full-duty code
  localparam logic [6:0]  CTRL1_RESET      = 7'h09;
  localparam logic [7:0]  OUT_STATE_RESET  = 8'haa;
  localparam logic [7:0]  GROUP_DUTY_RESET = 8'hff;
  localparam logic [7:0]  GROUP_PER_RESET  = 8'h00;
  localparam logic [7:0]  DUTY_RESET       = 8'h00;
  localparam logic [7:0]  DUTY_FULL        = 8'hff;

  // Channel state encodings
  localparam logic [1:0] CH_OFF      = 2'b00;
  localparam logic [1:0] CH_FULL     = 2'b01;
  localparam logic [1:0] CH_PWM      = 2'b10;
  localparam logic [1:0] CH_PWM_GRP  = 2'b11;

endpackage

//--- duty_mem.sv
// Per-channel duty store with one write port, a broadcast write and two read ports.
// Assumes writes come from the register decoder on the same clock; reads return after one edge.
`timescale 1ns/1ps
module duty_mem
  import led_mode_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Write side
  input  wire logic             wr_en,
  input  wire logic             wr_all,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port a (register reads)
  input  wire logic [AW-1:0]    rd_a_addr,
  output logic      [WIDTH-1:0] rd_a_data,
  // Read port b (output scan)
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [WIDTH-1:0] rd_b_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage; the broadcast write takes every word at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(DUTY_RESET);
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (wr_all || (wr_en && wr_addr == AW'(i))) begin
          mem[i] <= wr_data;
        end
      end
    end
  end

  // Registered read data on both ports
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule

//--- led_mode_regs_sva.sv
// Port checker for the mode and output-state register bank.
// Assumes it is bound to led_mode_regs and shares its one clock.
`timescale 1ns/1ps
module led_mode_regs_sva
  import led_mode_pkg::*;
#(
  parameter int CHANNELS      = 16,
  parameter int OSC_START_CYC = OSC_START_CYCLES
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rstn,
  // Register writes and fault inputs
  input wire logic [6:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic [CHANNELS-1:0] fault_detect,
  // Mode outputs
  input wire logic                autoinc_range_hi,
  input wire logic                autoinc_range_lo,
  input wire logic                subaddr_one_enable,
  input wire logic                subaddr_two_enable,
  input wire logic                subaddr_three_enable,
  input wire logic                broadcast_addr_enable,
  input wire logic                group_dim_or_blink,
  input wire logic                output_update_timing,
  input wire logic                exponential_ramp_select,
  input wire logic                osc_enable,
  // Fault outputs
  input wire logic [CHANNELS-1:0] output_fault_flags,
  input wire logic                error_summary
);
  // One clock domain, quiet while reset is low
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Byte writes to the two mode registers
  sequence s_ctrl1_wr;
    reg_wr && reg_addr == ADDR_CTRL1;
  endsequence
  sequence s_ctrl2_wr;
    reg_wr && reg_addr == ADDR_CTRL2;
  endsequence
  // Oscillator request may trail the other mode bits by one edge
  property p_sleep;
    logic s;
    (s_ctrl1_wr, s = reg_wdata[4]) |-> ##2 osc_enable == !s;
  endproperty

  a_range_bits:
    assert property (s_ctrl1_wr |=> {autoinc_range_hi, autoinc_range_lo} == $past(reg_wdata[6:5]))
    else $error("autoinc range bits wrong");
  a_sleep_osc:
    assert property (p_sleep)
    else $error("oscillator request wrong");
  a_sub_bits:
    assert property (s_ctrl1_wr |=> {subaddr_one_enable, subaddr_two_enable,
      subaddr_three_enable} == $past(reg_wdata[3:1]))
    else $error("sub-address enables wrong");
  a_bcast_bit:
    assert property (s_ctrl1_wr |=> broadcast_addr_enable == $past(reg_wdata[0]))
    else $error("broadcast enable wrong");
  a_ctrl2_bits:
    assert property (s_ctrl2_wr |=> {group_dim_or_blink, output_update_timing,
      exponential_ramp_select} == {$past(reg_wdata[5]), $past(reg_wdata[3:2])})
    else $error("second mode bits wrong");
  a_err_summary:
    assert property (error_summary == |output_fault_flags)
    else $error("error summary wrong");
  a_fault_set:
    assert property (1'b1 |=> (output_fault_flags & $past(fault_detect)) == $past(fault_detect))
    else $error("fault flag not set");
  a_fault_clear:
    assert property ((s_ctrl2_wr ##0 reg_wdata[4]) |=> output_fault_flags == $past(fault_detect))
    else $error("fault clear wrong");
endmodule

bind led_mode_regs led_mode_regs_sva #(.CHANNELS(CHANNELS), .OSC_START_CYC(OSC_START_CYC))
  led_mode_regs_sva_inst (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .fault_detect,
  .autoinc_range_hi, .autoinc_range_lo, .subaddr_one_enable, .subaddr_two_enable,
  .subaddr_three_enable, .broadcast_addr_enable, .group_dim_or_blink, .output_update_timing,
  .exponential_ramp_select, .osc_enable, .output_fault_flags, .error_summary);

//--- host_model.sv
// Bus host model: register strobes plus STOP and ACK event strobes.
// Assumes read data arrives two edges after the read strobe.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic       sys_clk,
  // Requests to the bank
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            bus_stop,
  output logic            bus_ack,
  // Answer from the bank
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle bus, nothing qualified
  initial begin
    reg_addr = 7'h7f;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bus_stop = 1'b0;
    bus_ack = 1'b0;
  end

  // Address and data inverted after use, so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read waits a bounded time for the valid strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 6) begin
      @(posedge sys_clk) #1;
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask

  // One-cycle STOP or ACK event
  task automatic evt(input logic use_ack);
    @(posedge sys_clk) #1;
    bus_stop = !use_ack;
    bus_ack = use_ack;
    @(posedge sys_clk) #1;
    bus_stop = 1'b0;
    bus_ack = 1'b0;
  endtask

  // Stay off the duty and group registers while the oscillator starts
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the mode and output-state register bank.
// Assumes the host model drives the register side; faults and pins come from here.
`timescale 1ns/1ps
module tb_top;
  import led_mode_pkg::*;
  localparam int OSC_SIM = 20;
  logic        sys_clk, rstn, autoinc_active_flag, thermal_fault_flag, oe_n_pin;
  logic [15:0] fault_detect, output_fault_flags, led_drive;
  logic [7:0]  reg_rdata, reg_wdata;
  logic [6:0]  reg_addr;
  logic        reg_wr, reg_rd, reg_rvalid, bus_stop, bus_ack, error_summary, osc_enable;
  logic        autoinc_range_hi, autoinc_range_lo, subaddr_one_enable, subaddr_two_enable;
  logic        subaddr_three_enable, broadcast_addr_enable, group_dim_or_blink;
  logic        output_update_timing, exponential_ramp_select;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  led_mode_regs #(.OSC_START_CYC(OSC_SIM)) led_mode_regs_inst (.sys_clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .bus_stop, .bus_ack,
    .autoinc_active_flag, .fault_detect, .thermal_fault_flag, .oe_n_pin, .autoinc_range_hi,
    .autoinc_range_lo, .subaddr_one_enable, .subaddr_two_enable, .subaddr_three_enable,
    .broadcast_addr_enable, .group_dim_or_blink, .output_update_timing,
    .exponential_ramp_select, .osc_enable, .led_drive, .output_fault_flags, .error_summary);
  host_model host_model_inst (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .bus_stop,
    .bus_ack, .reg_rdata, .reg_rvalid);

  // 250 MHz clock and a cycle ceiling against hangs
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset values, plus an unmapped address that must read zero
  task automatic t_reset;
    rdchk(ADDR_CTRL1, 8'h89);
    rdchk(ADDR_CTRL2, 8'h01);
    for (int i = 2; i < 6; i++) rdchk(7'(i), 8'haa);
    rdchk(7'h50, 8'h00);
  endtask

  // Second mode bits both ways, read-only bits not writable
  task automatic t_ctrl2;
    thermal_fault_flag = 1'b1;
    host_model_inst.wr(ADDR_CTRL2, 8'hff);
    rdchk(ADDR_CTRL2, 8'had);
    thermal_fault_flag = 1'b0;
    host_model_inst.wr(ADDR_CTRL2, 8'h00);
    rdchk(ADDR_CTRL2, 8'h01);
  endtask

  // Flags latch, clear is overridden by a live fault
  task automatic t_fault;
    fault_detect = 16'h8001;
    tick(1);
    fault_detect = 16'h0001;
    tick(1);
    chk(output_fault_flags, 16'h8001);
    rdchk(ADDR_CTRL2, 8'h41);
    rdchk(ADDR_FAULT_HI, 8'h80);
    host_model_inst.wr(ADDR_CTRL2, 8'h10);
    chk(output_fault_flags, 16'h0001);
    rdchk(ADDR_CTRL2, 8'h41);
    fault_detect = 16'h0000;
    host_model_inst.wr(ADDR_CTRL2, 8'h10);
    chk(output_fault_flags, 16'h0000);
    chk(16'(error_summary), 16'h0000);
  endtask

  // Ch0 state 10 at FFh, ch1 01, ch2 11 at FFh under group duty 00h, ch3 00
  task automatic t_outputs;
    host_model_inst.settle(OSC_SIM);
    host_model_inst.wr(ADDR_DUTY_FIRST, 8'hff);
    host_model_inst.wr(ADDR_DUTY_FIRST + 7'h02, 8'hff);
    host_model_inst.wr(ADDR_GROUP_DUTY, 8'h00);
    rdchk(ADDR_DUTY_FIRST, 8'hff);
    host_model_inst.wr(ADDR_OUT_STATE0, 8'h36);
    host_model_inst.evt(1'b0);
    tick(60);
    chk(led_drive[3:0], 4'b0011);
    oe_n_pin = 1'b1;
    tick(8);
    chk(led_drive, 16'h0000);
    oe_n_pin = 1'b0;
    host_model_inst.wr(ADDR_CTRL2, 8'h08);
    host_model_inst.wr(ADDR_OUT_STATE0, 8'h00);
    host_model_inst.evt(1'b0);
    tick(60);
    chk(led_drive[3:0], 4'b0011);
    host_model_inst.evt(1'b1);
    tick(60);
    chk(led_drive[3:0], 4'b0000);
    host_model_inst.wr(ADDR_OUT_STATE0, 8'h36);
    host_model_inst.evt(1'b1);
    host_model_inst.wr(ADDR_DUTY_ALL, 8'h00);
    tick(60);
    chk(led_drive[3:0], 4'b0010);
  endtask

  // Sleep freezes PWM but not state 01; wake checked 60 cycles after the start window
  task automatic t_sleep;
    host_model_inst.wr(ADDR_DUTY_FIRST, 8'hff);
    autoinc_active_flag = 1'b0;
    host_model_inst.wr(ADDR_CTRL1, 8'hf6);
    rdchk(ADDR_CTRL1, 8'h76);
    chk({autoinc_range_hi, autoinc_range_lo, subaddr_one_enable, subaddr_two_enable,
      subaddr_three_enable, broadcast_addr_enable, osc_enable}, 16'h006c);
    tick(60);
    chk(led_drive[3:0], 4'b0010);
    host_model_inst.wr(ADDR_CTRL1, 8'h09);
    tick(OSC_SIM + 60);
    chk({osc_enable, led_drive[3:0]}, 5'b10011);
  endtask

  // Reset held two cycles, then each scenario in turn
  initial begin
    rstn = 1'b0;
    autoinc_active_flag = 1'b1;
    thermal_fault_flag = 1'b0;
    oe_n_pin = 1'b0;
    fault_detect = 16'h0000;
    tick(2);
    rstn = 1'b1;
    t_reset();
    t_ctrl2();
    t_fault();
    t_outputs();
    t_sleep();
    close_out();
  end
endmodule
